//--- verilog/osic_pkg.sv
/*
  Constants for the optical sensor interrupt and measurement configuration block:
  register offsets, field positions, reset values and timing counts.
  Assumes the serial register decoder presents byte-wide register accesses.
*/
// What this block does
// - Change mode fires on step of 8..1024 counts.
// - Two-bit field picks compared light channel.
// - Mode bit: threshold window or change compare.
// - Light events reach pin only when enabled.
// - Almost-full reaches pin only when enabled.
// - Pulse data events reach pin when enabled.
// - Normal mode: pin held until status read.
// - Level mode: pin follows proximity, others suppressed.
// - Proximity events reach pin only when enabled.
// - Light needs N+1 consecutive out-of-range results.
// - Proximity needs N+1 consecutive out-of-range results.
// - Gain field selects 1, 1.5, 2 or 4.
// - Power save on gaps of 50 us.
// - Order bit 0: infrared first, red second.
// - Order bit 1: red first, infrared second.
// - Proximity above upper threshold is an event.
// - Proximity below lower threshold is an event.
// - Light below lower threshold is an event.
package osic_pkg;
  localparam logic [7:0] OFS_LIGHT_CHANGE_STEP = 8'h2A;
  localparam logic [7:0] OFS_LIGHT_IRQ_CONFIG = 8'h2B;
  localparam logic [7:0] OFS_PROX_PULSE_IRQ_CONFIG = 8'h2C;
  localparam logic [7:0] OFS_IRQ_PERSISTENCE = 8'h2D;
  localparam logic [7:0] OFS_FRONT_END_GAIN = 8'h2E;
  localparam logic [7:0] OFS_PULSE_PROX_CONFIG = 8'h2F;
  localparam logic [7:0] RST_LIGHT_CHANGE_STEP = 8'h00;
  localparam logic [7:0] RST_LIGHT_IRQ_CONFIG = 8'h10;
  localparam logic [7:0] RST_PROX_PULSE_IRQ_CONFIG = 8'h00;
  localparam logic [7:0] RST_IRQ_PERSISTENCE = 8'h00;
  localparam logic [7:0] RST_FRONT_END_GAIN = 8'h09;
  localparam logic [7:0] RST_PULSE_PROX_CONFIG = 8'h40;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Field positions.
  localparam int STEP_LSB = 0;
  localparam int CHAN_LSB = 4;
  localparam int CHANGE_MODE_BIT = 1;
  localparam int LIGHT_EN_BIT = 0;
  localparam int AFULL_EN_BIT = 5;
  localparam int PULSE_EN_BIT = 4;
  localparam int LEVEL_MODE_BIT = 1;
  localparam int PROX_EN_BIT = 0;
  localparam int LIGHT_PST_LSB = 4;
  localparam int PROX_PST_LSB = 0;
  localparam int GAIN_LSB = 4;
  localparam int POWERSAVE_BIT = 6;
  localparam int SWAP_BIT = 3;
  // Fixed ones of the gain register read back as laid out.
  localparam logic [7:0] GAIN_FIXED_ONES = 8'h09;
  localparam logic [1:0] CHAN_CLEAR = 2'h0;
  localparam logic [1:0] CHAN_GREEN = 2'h1;
  localparam logic [1:0] CHAN_RED = 2'h2;
  localparam logic [1:0] CHAN_BLUE = 2'h3;
  localparam int STEP_BASE_LOG2 = 3;
  // Gain in half steps: 1, 1.5, 2, 4 times.
  localparam logic [3:0] GAIN_X1_HALF = 4'h2;
  localparam logic [3:0] GAIN_X15_HALF = 4'h3;
  localparam logic [3:0] GAIN_X2_HALF = 4'h4;
  localparam logic [3:0] GAIN_X4_HALF = 4'h8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int POWERSAVE_MIN_GAP_NS = 50000;
  localparam int POWERSAVE_MIN_GAP_CYC = (POWERSAVE_MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : osic_pkg

//--- verilog/osic_irq_ctrl.sv
/*
  Interrupt and measurement configuration block of the optical sensor: six
  configuration registers, light and proximity event detection with persistence,
  interrupt pin control, gain decode, pulse power save and emitter ordering.
  Assumes threshold storage, result paths and the status register live outside,
  and that register accesses arrive from the serial decoder as one-cycle strobes.
*/
`timescale 1ns/1ns
module osic_irq_ctrl
  import osic_pkg::*;
#(
  parameter int LIGHT_W = 20,
  parameter int PROX_W = 16,
  parameter int GAP_W = 16
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register access from the serial decoder.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic status_read,
  // Light results and thresholds.
  input wire logic light_valid,
  input wire logic [LIGHT_W-1:0] light_result_clear,
  input wire logic [LIGHT_W-1:0] light_result_green,
  input wire logic [LIGHT_W-1:0] light_result_red,
  input wire logic [LIGHT_W-1:0] light_result_blue,
  input wire logic [LIGHT_W-1:0] light_thr_up,
  input wire logic [LIGHT_W-1:0] light_thr_low,
  // Proximity results and thresholds.
  input wire logic prox_valid,
  input wire logic [PROX_W-1:0] proximity_result,
  input wire logic [PROX_W-1:0] prox_thr_up,
  input wire logic [PROX_W-1:0] prox_thr_low,
  // Pulse measurement events and timing.
  input wire logic pulse_data_event,
  input wire logic fifo_almost_full,
  input wire logic pulse_meas_active,
  input wire logic [GAP_W-1:0] pulse_idle_gap_cycles,
  input wire logic emitter_fire,
  input wire logic pulse_dual_emitter_mode,
  input wire logic pulse_second_sample,
  // Outputs to the pin and the analog side.
  output logic irq_n,
  output logic light_irq_pending,
  output logic prox_irq_pending,
  output logic afull_irq_pending,
  output logic pulse_irq_pending,
  output logic [1:0] optical_front_gain_sel,
  output logic [3:0] front_gain_half_steps,
  output logic pulse_idle_powerdown,
  output logic infrared_emitter_pin,
  output logic red_emitter_pin
);

  function automatic logic out_of_range(input logic [LIGHT_W-1:0] v,
                                        input logic [LIGHT_W-1:0] up,
                                        input logic [LIGHT_W-1:0] low);
    out_of_range = (v > up) || (v < low);
  endfunction : out_of_range

  // Saturating persistence count; falls to zero on any in-range result.
  // A limit lowered below a running count clamps at the next out-of-range result, so the count never wraps.
  function automatic logic [3:0] pst_next(input logic [3:0] cnt, input logic [3:0] lim,
                                          input logic hit);
    if (!hit)
      pst_next = 4'h0;
    else if (cnt >= lim)
      pst_next = lim;
    else
      pst_next = cnt + 4'h1;
  endfunction : pst_next

  logic [2:0] step_sel_reg, step_sel_next;
  logic [1:0] chan_sel_reg, chan_sel_next;
  logic change_mode_reg, change_mode_next;
  logic light_en_reg, light_en_next;
  logic afull_en_reg, afull_en_next;
  logic pulse_en_reg, pulse_en_next;
  logic level_mode_reg, level_mode_next;
  logic prox_en_reg, prox_en_next;
  logic [3:0] light_pst_reg, light_pst_next;
  logic [3:0] prox_pst_reg, prox_pst_next;
  logic [1:0] gain_reg, gain_next;
  logic powersave_reg, powersave_next;
  logic swap_reg, swap_next;
  logic [7:0] rdata_next;

  // Configuration registers; only defined fields are stored.
  always_comb
  begin
    step_sel_next = step_sel_reg;
    chan_sel_next = chan_sel_reg;
    change_mode_next = change_mode_reg;
    light_en_next = light_en_reg;
    afull_en_next = afull_en_reg;
    pulse_en_next = pulse_en_reg;
    level_mode_next = level_mode_reg;
    prox_en_next = prox_en_reg;
    light_pst_next = light_pst_reg;
    prox_pst_next = prox_pst_reg;
    gain_next = gain_reg;
    powersave_next = powersave_reg;
    swap_next = swap_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_LIGHT_CHANGE_STEP: step_sel_next = reg_wdata[STEP_LSB +: 3];
        OFS_LIGHT_IRQ_CONFIG:
        begin
          chan_sel_next = reg_wdata[CHAN_LSB +: 2];
          change_mode_next = reg_wdata[CHANGE_MODE_BIT];
          light_en_next = reg_wdata[LIGHT_EN_BIT];
        end
        OFS_PROX_PULSE_IRQ_CONFIG:
        begin
          afull_en_next = reg_wdata[AFULL_EN_BIT];
          pulse_en_next = reg_wdata[PULSE_EN_BIT];
          level_mode_next = reg_wdata[LEVEL_MODE_BIT];
          prox_en_next = reg_wdata[PROX_EN_BIT];
        end
        OFS_IRQ_PERSISTENCE:
        begin
          light_pst_next = reg_wdata[LIGHT_PST_LSB +: 4];
          prox_pst_next = reg_wdata[PROX_PST_LSB +: 4];
        end
        OFS_FRONT_END_GAIN: gain_next = reg_wdata[GAIN_LSB +: 2];
        OFS_PULSE_PROX_CONFIG:
        begin
          powersave_next = reg_wdata[POWERSAVE_BIT];
          swap_next = reg_wdata[SWAP_BIT];
        end
        default: ;
      endcase
    end
    rdata_next = reg_rdata;
    if (reg_rd)
    begin
      rdata_next = RD_UNMAPPED;
      case (reg_addr)
        OFS_LIGHT_CHANGE_STEP: rdata_next[STEP_LSB +: 3] = step_sel_reg;
        OFS_LIGHT_IRQ_CONFIG:
        begin
          rdata_next[CHAN_LSB +: 2] = chan_sel_reg;
          rdata_next[CHANGE_MODE_BIT] = change_mode_reg;
          rdata_next[LIGHT_EN_BIT] = light_en_reg;
        end
        OFS_PROX_PULSE_IRQ_CONFIG:
        begin
          rdata_next[AFULL_EN_BIT] = afull_en_reg;
          rdata_next[PULSE_EN_BIT] = pulse_en_reg;
          rdata_next[LEVEL_MODE_BIT] = level_mode_reg;
          rdata_next[PROX_EN_BIT] = prox_en_reg;
        end
        OFS_IRQ_PERSISTENCE: rdata_next = {light_pst_reg, prox_pst_reg};
        OFS_FRONT_END_GAIN:
        begin
          rdata_next = GAIN_FIXED_ONES;
          rdata_next[GAIN_LSB +: 2] = gain_reg;
        end
        OFS_PULSE_PROX_CONFIG:
        begin
          rdata_next[POWERSAVE_BIT] = powersave_reg;
          rdata_next[SWAP_BIT] = swap_reg;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      step_sel_reg <= RST_LIGHT_CHANGE_STEP[STEP_LSB +: 3];
      chan_sel_reg <= RST_LIGHT_IRQ_CONFIG[CHAN_LSB +: 2];
      change_mode_reg <= RST_LIGHT_IRQ_CONFIG[CHANGE_MODE_BIT];
      light_en_reg <= RST_LIGHT_IRQ_CONFIG[LIGHT_EN_BIT];
      afull_en_reg <= RST_PROX_PULSE_IRQ_CONFIG[AFULL_EN_BIT];
      pulse_en_reg <= RST_PROX_PULSE_IRQ_CONFIG[PULSE_EN_BIT];
      level_mode_reg <= RST_PROX_PULSE_IRQ_CONFIG[LEVEL_MODE_BIT];
      prox_en_reg <= RST_PROX_PULSE_IRQ_CONFIG[PROX_EN_BIT];
      light_pst_reg <= RST_IRQ_PERSISTENCE[LIGHT_PST_LSB +: 4];
      prox_pst_reg <= RST_IRQ_PERSISTENCE[PROX_PST_LSB +: 4];
      gain_reg <= RST_FRONT_END_GAIN[GAIN_LSB +: 2];
      powersave_reg <= RST_PULSE_PROX_CONFIG[POWERSAVE_BIT];
      swap_reg <= RST_PULSE_PROX_CONFIG[SWAP_BIT];
      reg_rdata <= RD_UNMAPPED;
    end
    else
    begin
      step_sel_reg <= step_sel_next;
      chan_sel_reg <= chan_sel_next;
      change_mode_reg <= change_mode_next;
      light_en_reg <= light_en_next;
      afull_en_reg <= afull_en_next;
      pulse_en_reg <= pulse_en_next;
      level_mode_reg <= level_mode_next;
      prox_en_reg <= prox_en_next;
      light_pst_reg <= light_pst_next;
      prox_pst_reg <= prox_pst_next;
      gain_reg <= gain_next;
      powersave_reg <= powersave_next;
      swap_reg <= swap_next;
      reg_rdata <= rdata_next;
    end
  end

  // Event detection, persistence and pin state.
  logic [LIGHT_W-1:0] light_sel, light_prev_reg, light_prev_next, light_diff, light_step;
  logic light_prev_ok_reg, light_prev_ok_next;
  logic light_hit, prox_hit, light_event, prox_event;
  logic [3:0] light_cnt_reg, light_cnt_next, prox_cnt_reg, prox_cnt_next;
  logic light_pend_next, prox_pend_next, afull_pend_next, pulse_pend_next;
  logic afull_prev_reg, prox_level_reg, prox_level_next, irq_n_next;
  logic [LIGHT_W-1:0] prox_ext, prox_up_ext, prox_low_ext;

  always_comb
  begin
    case (chan_sel_reg)
      CHAN_CLEAR: light_sel = light_result_clear;
      CHAN_GREEN: light_sel = light_result_green;
      CHAN_RED: light_sel = light_result_red;
      CHAN_BLUE: light_sel = light_result_blue;
      default: light_sel = light_result_green;
    endcase
    light_step = LIGHT_W'(1) << (STEP_LSB + STEP_BASE_LOG2 + int'(step_sel_reg));
    light_diff = (light_sel >= light_prev_reg) ? light_sel - light_prev_reg
                                               : light_prev_reg - light_sel;
    // The first result after reset has nothing to compare against.
    if (change_mode_reg)
      light_hit = light_prev_ok_reg && (light_diff >= light_step);
    else
      light_hit = out_of_range(light_sel, light_thr_up, light_thr_low);
    prox_ext = LIGHT_W'(proximity_result);
    prox_up_ext = LIGHT_W'(prox_thr_up);
    prox_low_ext = LIGHT_W'(prox_thr_low);
    prox_hit = out_of_range(prox_ext, prox_up_ext, prox_low_ext);
    light_event = light_valid && light_hit && (light_cnt_reg >= light_pst_reg);
    prox_event = prox_valid && prox_hit && (prox_cnt_reg >= prox_pst_reg);
    light_cnt_next = light_valid ? pst_next(light_cnt_reg, light_pst_reg, light_hit)
                                 : light_cnt_reg;
    prox_cnt_next = prox_valid ? pst_next(prox_cnt_reg, prox_pst_reg, prox_hit)
                               : prox_cnt_reg;
    light_prev_next = light_valid ? light_sel : light_prev_reg;
    light_prev_ok_next = light_prev_ok_reg || light_valid;
    // A new event in the cycle of the status read wins over the clear.
    light_pend_next = (light_event && light_en_reg) || (light_irq_pending && !status_read);
    prox_pend_next = (prox_event && prox_en_reg) || (prox_irq_pending && !status_read);
    afull_pend_next = (fifo_almost_full && !afull_prev_reg && afull_en_reg)
                      || (afull_irq_pending && !status_read);
    pulse_pend_next = (pulse_data_event && pulse_en_reg)
                      || (pulse_irq_pending && !status_read);
    // Level mode tracks near above upper, far below lower, holds in between.
    prox_level_next = prox_level_reg;
    if (prox_valid && proximity_result > prox_thr_up)
      prox_level_next = 1'b1;
    else if (prox_valid && proximity_result < prox_thr_low)
      prox_level_next = 1'b0;
    if (level_mode_reg)
      irq_n_next = !(prox_level_reg && prox_en_reg);
    else
      irq_n_next = !(light_irq_pending || prox_irq_pending || afull_irq_pending
                     || pulse_irq_pending);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      light_prev_reg <= '0;
      light_prev_ok_reg <= 1'b0;
      light_cnt_reg <= 4'h0;
      prox_cnt_reg <= 4'h0;
      light_irq_pending <= 1'b0;
      prox_irq_pending <= 1'b0;
      afull_irq_pending <= 1'b0;
      pulse_irq_pending <= 1'b0;
      afull_prev_reg <= 1'b0;
      prox_level_reg <= 1'b0;
      irq_n <= 1'b1;
    end
    else
    begin
      light_prev_reg <= light_prev_next;
      light_prev_ok_reg <= light_prev_ok_next;
      light_cnt_reg <= light_cnt_next;
      prox_cnt_reg <= prox_cnt_next;
      light_irq_pending <= light_pend_next;
      prox_irq_pending <= prox_pend_next;
      afull_irq_pending <= afull_pend_next;
      pulse_irq_pending <= pulse_pend_next;
      afull_prev_reg <= fifo_almost_full;
      prox_level_reg <= prox_level_next;
      irq_n <= irq_n_next;
    end
  end

  // Analog side controls.
  logic [3:0] gain_half_next;
  logic powerdown_next, first_slot, ir_next, red_next;

  always_comb
  begin
    case (gain_reg)
      2'h0: gain_half_next = GAIN_X1_HALF;
      2'h1: gain_half_next = GAIN_X15_HALF;
      2'h2: gain_half_next = GAIN_X2_HALF;
      2'h3: gain_half_next = GAIN_X4_HALF;
      default: gain_half_next = GAIN_X1_HALF;
    endcase
    // Short gaps keep the front end up; waking it costs more than it saves.
    powerdown_next = powersave_reg && !pulse_meas_active
                     && (32'(pulse_idle_gap_cycles) >= POWERSAVE_MIN_GAP_CYC);
    first_slot = !(pulse_dual_emitter_mode && pulse_second_sample);
    ir_next = emitter_fire && (first_slot ^ swap_reg);
    red_next = emitter_fire && !(first_slot ^ swap_reg);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      optical_front_gain_sel <= 2'h0;
      front_gain_half_steps <= GAIN_X1_HALF;
      pulse_idle_powerdown <= 1'b0;
      infrared_emitter_pin <= 1'b0;
      red_emitter_pin <= 1'b0;
    end
    else
    begin
      optical_front_gain_sel <= gain_reg;
      front_gain_half_steps <= gain_half_next;
      pulse_idle_powerdown <= powerdown_next;
      infrared_emitter_pin <= ir_next;
      red_emitter_pin <= red_next;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_light_gate: assert property ($rose(light_irq_pending) |-> $past(light_en_reg))
    else $error("light pending set while disabled");
  a_prox_gate: assert property ($rose(prox_irq_pending) |-> $past(prox_en_reg))
    else $error("proximity pending set while disabled");
  a_afull_gate: assert property ($rose(afull_irq_pending) |-> $past(afull_en_reg))
    else $error("almost-full pending set while disabled");
  a_pulse_gate: assert property ($rose(pulse_irq_pending) |-> $past(pulse_en_reg))
    else $error("pulse pending set while disabled");
  a_pin_held: assert property (!level_mode_reg && light_irq_pending && !status_read
    |=> light_irq_pending ##1 !irq_n || level_mode_reg)
    else $error("pin released before status read");
  a_level_pin: assert property (level_mode_reg && !$changed(level_mode_reg)
    |-> irq_n == !($past(prox_level_reg) && $past(prox_en_reg)))
    else $error("level mode pin mismatch");
  a_pst_zero: assert property (light_valid && !light_hit |=> light_cnt_reg == 4'h0)
    else $error("light persistence not cleared");
  a_step_fire: assert property (light_valid && change_mode_reg && light_prev_ok_reg
    && light_diff >= light_step && light_pst_reg == 4'h0 && light_en_reg
    |=> light_irq_pending)
    else $error("change step event missed");
  a_pst_two: assert property (light_pst_reg == 4'h1 && light_cnt_reg == 4'h0
    && !light_irq_pending && !status_read && light_valid && !reg_wr
    |=> !light_irq_pending)
    else $error("light fired before second result");
  a_power_gap: assert property (pulse_idle_powerdown
    |-> $past(powersave_reg) && 32'($past(pulse_idle_gap_cycles)) >= POWERSAVE_MIN_GAP_CYC)
    else $error("powerdown on short gap");
  a_emitter_one: assert property (!(infrared_emitter_pin && red_emitter_pin))
    else $error("both emitters on");
  c_change_event: cover property (change_mode_reg && light_event && light_en_reg);
  c_level_mode: cover property (level_mode_reg && $fell(irq_n));
  c_afull: cover property ($rose(afull_irq_pending));
  c_swap_fire: cover property (swap_reg && infrared_emitter_pin);

endmodule : osic_irq_ctrl

//--- tb/osic_host_model.sv
/*
  Host processor model for the optical sensor configuration block: byte
  register writes and reads and the status read that acknowledges the pin.
  Assumes one caller at a time, driving just after falling clock edges.
*/
`timescale 1ns/1ns
module osic_host_model
(
  // Clock.
  input wire logic ref_clk,
  // Register access towards the block.
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic status_read,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'hFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    status_read = 1'b0;
  end

  // Software keeps the fixed bits of each layout, whatever the caller asks.
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h2A: legal = d & 8'h07;
      8'h2B, 8'h2C: legal = d & 8'h33;
      8'h2E: legal = (d & 8'h30) | 8'h09;
      8'h2F: legal = d & 8'h48;
      default: legal = d;
    endcase
  endfunction : legal

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = legal(a, d);
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    reg_addr = ~a;
  endtask : rd

  task automatic ack();
    @(negedge ref_clk);
    status_read = 1'b1;
    @(negedge ref_clk);
    status_read = 1'b0;
  endtask : ack
endmodule : osic_host_model

//--- tb/optical_sensor_irq_config_tb.sv
/*
  Self-checking bench for the optical sensor interrupt configuration block.
  Assumes the host model drives the register side and the bench the rest.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module optical_sensor_irq_config_tb;
  import osic_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, status_read, light_valid, prox_valid, pulse_ev, afull, meas, fire;
  logic dual, second, irq_n, pdown, ir_pin, red_pin, light_p, prox_p, afull_p, pulse_p;
  logic [19:0] lr_red, lr_oth;
  logic [15:0] prox_res, gap;
  logic [1:0] gsel;
  logic [3:0] ghalf;
  logic [7:0] rst_val [6] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h09, 8'h40};
  logic [3:0] halves [4] = '{4'h2, 4'h3, 4'h4, 4'h8};
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;

  osic_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .status_read(status_read), .reg_rdata(reg_rdata));

  osic_irq_ctrl DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_read(status_read), .light_valid(light_valid), .light_result_clear(lr_oth),
    .light_result_green(lr_oth), .light_result_red(lr_red), .light_result_blue(lr_oth),
    .light_thr_up(20'h00200), .light_thr_low(20'h00080), .prox_valid(prox_valid),
    .proximity_result(prox_res), .prox_thr_up(16'h1000), .prox_thr_low(16'h0100),
    .pulse_data_event(pulse_ev), .fifo_almost_full(afull), .pulse_meas_active(meas),
    .pulse_idle_gap_cycles(gap), .emitter_fire(fire), .pulse_dual_emitter_mode(dual),
    .pulse_second_sample(second), .irq_n(irq_n), .light_irq_pending(light_p),
    .prox_irq_pending(prox_p), .afull_irq_pending(afull_p), .pulse_irq_pending(pulse_p),
    .optical_front_gain_sel(gsel), .front_gain_half_steps(ghalf),
    .pulse_idle_powerdown(pdown), .infrared_emitter_pin(ir_pin), .red_emitter_pin(red_pin));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // The ceiling is well above the few hundred cycles the tests need.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic light(input logic [19:0] r);
    @(negedge ref_clk);
    lr_red = r;
    light_valid = 1'b1;
    @(negedge ref_clk);
    light_valid = 1'b0;
    lr_red = ~r;
    tick(3);
  endtask : light

  task automatic prox(input logic [15:0] r);
    @(negedge ref_clk);
    prox_res = r;
    prox_valid = 1'b1;
    @(negedge ref_clk);
    prox_valid = 1'b0;
    prox_res = ~r;
    tick(3);
  endtask : prox

  task automatic clear_all();
    host.ack();
    tick(3);
    `CHK({light_p, prox_p, afull_p, pulse_p, irq_n}, 5'h01)
  endtask : clear_all

  task automatic t_reset();
    for (int i = 0; i < 6; i++)
    begin
      host.rd(8'h2A + 8'(i), rv);
      `CHK(rv, rst_val[i])
    end
    host.wr(8'h30, 8'h5A);
    host.rd(8'h30, rv);
    `CHK(rv, RD_UNMAPPED)
    `CHK({irq_n, gsel, ghalf}, 7'h42)
    $display("reset test done");
  endtask : t_reset

  task automatic t_light_thr();
    host.wr(8'h2D, 8'h10);
    host.wr(8'h2B, 8'h21);
    host.rd(8'h2B, rv);
    `CHK(rv, 8'h21)
    light(20'h00010);
    `CHK({light_p, irq_n}, 2'b01)
    light(20'h00100);
    light(20'h00010);
    `CHK({light_p, irq_n}, 2'b01)
    light(20'h00010);
    `CHK({light_p, irq_n}, 2'b10)
    clear_all();
    $display("light threshold test done");
  endtask : t_light_thr

  task automatic t_change();
    host.wr(8'h2D, 8'h00);
    host.wr(8'h2A, 8'h00);
    host.wr(8'h2B, 8'h23);
    light(20'h00100);
    clear_all();
    light(20'h00107);
    `CHK({light_p, irq_n}, 2'b01)
    light(20'h0010F);
    `CHK({light_p, irq_n}, 2'b10)
    clear_all();
    host.wr(8'h2B, 8'h22);
    light(20'h00010);
    `CHK({light_p, irq_n}, 2'b01)
    clear_all();
    $display("change test done");
  endtask : t_change

  task automatic t_prox();
    host.wr(8'h2C, 8'h01);
    prox(16'h2000);
    `CHK({prox_p, irq_n}, 2'b10)
    clear_all();
    prox(16'h0050);
    `CHK({prox_p, irq_n}, 2'b10)
    clear_all();
    prox(16'h0500);
    `CHK({prox_p, irq_n}, 2'b01)
    host.wr(8'h2D, 8'h01);
    prox(16'h2000);
    `CHK({prox_p, irq_n}, 2'b01)
    host.wr(8'h2C, 8'h13);
    prox(16'h2000);
    `CHK(irq_n, 1'b0)
    pulse_ev = 1'b1;
    tick(1);
    pulse_ev = 1'b0;
    prox(16'h0500);
    `CHK(irq_n, 1'b0)
    prox(16'h0050);
    `CHK({pulse_p, irq_n}, 2'b11)
    host.wr(8'h2C, 8'h00);
    clear_all();
    $display("proximity test done");
  endtask : t_prox

  task automatic t_fifo();
    afull = 1'b1;
    pulse_ev = 1'b1;
    tick(1);
    pulse_ev = 1'b0;
    tick(3);
    `CHK({afull_p, pulse_p, irq_n}, 3'b001)
    afull = 1'b0;
    host.wr(8'h2C, 8'h30);
    afull = 1'b1;
    tick(4);
    `CHK({afull_p, pulse_p, irq_n}, 3'b100)
    pulse_ev = 1'b1;
    tick(1);
    pulse_ev = 1'b0;
    tick(3);
    `CHK({afull_p, pulse_p, irq_n}, 3'b110)
    clear_all();
    afull = 1'b0;
    $display("buffer event test done");
  endtask : t_fifo

  task automatic t_analog();
    for (int g = 0; g < 4; g++)
    begin
      host.wr(8'h2E, {2'h0, 2'(g), 4'h0});
      tick(2);
      `CHK({gsel, ghalf}, {2'(g), halves[g]})
      host.rd(8'h2E, rv);
      `CHK(rv, {2'h0, 2'(g), 4'h9})
    end
    gap = 16'h04E2;
    tick(2);
    `CHK(pdown, 1'b1)
    meas = 1'b1;
    tick(2);
    `CHK(pdown, 1'b0)
    meas = 1'b0;
    gap = 16'h04E1;
    tick(2);
    `CHK(pdown, 1'b0)
    fire = 1'b1;
    dual = 1'b1;
    tick(2);
    `CHK({ir_pin, red_pin}, 2'b10)
    second = 1'b1;
    tick(2);
    `CHK({ir_pin, red_pin}, 2'b01)
    host.wr(8'h2F, 8'h08);
    gap = 16'h04E2;
    tick(2);
    `CHK({ir_pin, red_pin, pdown}, 3'b100)
    second = 1'b0;
    tick(2);
    `CHK({ir_pin, red_pin}, 2'b01)
    $display("analog test done");
  endtask : t_analog

  initial
  begin
    {light_valid, prox_valid, pulse_ev, afull, meas, fire, dual, second} = 8'h00;
    lr_red = 20'h00100;
    lr_oth = 20'h00100;
    prox_res = 16'h0500;
    gap = 16'h0000;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset();
    t_light_thr();
    t_change();
    t_prox();
    t_fifo();
    t_analog();
    results();
  end
endmodule : optical_sensor_irq_config_tb
